// ### sccs_defines.vh
`ifndef SCCS_DEFINES_VH
`define SCCS_DEFINES_VH
// Register indexes; byte address is four times the index
`define SCCS_IDX_CONTACT   12'h0ac
`define SCCS_IDX_STATUS    12'h0ad
`define SCCS_IDX_CONFIG    12'h0ae
`define SCCS_IDX_DATA      12'h0af
`define SCCS_IDX_IRQ_STAT  12'h0b0
`define SCCS_IDX_IRQ_MASK  12'h0b1
// Contact control fields
`define SCCS_CC_CLKSEL     7
`define SCCS_CC_AUX8       5
`define SCCS_CC_AUX4       4
`define SCCS_CC_IO         3
`define SCCS_CC_CLKLVL     2
`define SCCS_CC_RST        1
`define SCCS_CC_PWR        0
`define SCCS_CC_RSVD       6
`define SCCS_CC_RESET      8'h00
// Status fields
`define SCCS_ST_TBE        7
`define SCCS_ST_PRES       6
`define SCCS_ST_OVC        5
`define SCCS_ST_VOK        4
`define SCCS_ST_WTO        3
`define SCCS_ST_TC         2
`define SCCS_ST_RC         1
`define SCCS_ST_PE         0
`define SCCS_ST_RESET      8'h80
// Config fields
`define SCCS_CF_UART       3
`define SCCS_CF_VSEL_HI    5
`define SCCS_CF_VSEL_LO    4
`define SCCS_CF_OVC_ADJ    6
`define SCCS_CF_RESET      8'h00
// Interrupt mask
`define SCCS_IRQ_MASK_RESET 8'h00
// AHB encodings
`define SCCS_HTRANS_NONSEQ 2'b10
`define SCCS_HTRANS_SEQ    2'b11
`endif

// ### sccs_contacts.v
// Notes on behaviour
// - Contact bit 7 picks software clock level or generated card clock.
// - Contact bits 5 and 4 drive aux contacts eight and four, readable back.
// - IO bit drives the IO contact; set it before reading the pin back.
// - Bit 2 sets static clock level, changed only while voltage is in range.
// - Bit 1 drives reset contact, changed only while voltage is in range.
// - Bit 0 clear powers card off; other contact bits then have no effect.
// - Status bit 7 set on transmit copy, cleared by data write, resets to 1.
// - Status bit 6 follows card presence; software debounces it.
// - Status bit 5 shows overcurrent above selected limit; hardware clears it.
// - Status bit 4 shows supply voltage within selected range.
// - Status bit 3 set on waiting-time expiry, cleared on counter reload.
// - Status bit 2 set on successful transmit, cleared by status read.
// - Status bit 1 set on successful receive, cleared by data buffer read.
// - Status bit 0 set on parity error, cleared by status read.
// - Config bit 3 selects software IO bit or card UART for IO contact.
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "sccs_defines.vh"

module sccs_contacts #(
  parameter ADDR_W = 12
) (
  input  wire              hclk,
  input  wire              hresetn,
  input  wire              ce,
  input  wire              hsel,
  input  wire [31:0]       haddr,
  input  wire [1:0]        htrans,
  input  wire              hwrite,
  input  wire [2:0]        hsize,
  input  wire [31:0]       hwdata,
  input  wire              hready,
  output reg               hreadyout,
  output reg               hresp,
  output reg  [31:0]       hrdata,
  input  wire              card_present,
  input  wire              overcurrent_in,
  input  wire              voltage_in_range,
  input  wire              generated_card_clock,
  input  wire              tx_load_evt,
  input  wire              tx_done_ok_evt,
  input  wire              rx_done_ok_evt,
  input  wire              parity_err_evt,
  input  wire              wait_expire_evt,
  input  wire              wait_reload_evt,
  input  wire              uart_io_level,
  input  wire [7:0]        rx_data,
  input  wire              io_pin_i,
  input  wire              aux_pin_eight_i,
  input  wire              aux_pin_four_i,
  output reg               io_pin_o,
  output reg               io_pin_oe,
  output reg               aux_pin_eight_o,
  output reg               aux_pin_eight_oe,
  output reg               aux_pin_four_o,
  output reg               aux_pin_four_oe,
  output reg               card_clk_o,
  output reg               card_rst_o,
  output reg               card_power_on,
  output reg  [1:0]        supply_voltage_select,
  output reg               overcurrent_limit_adjust,
  output reg               uart_select,
  output reg  [7:0]        tx_data,
  output reg               tx_data_wr,
  output reg               irq
);

  // Word index of a byte address
  // Address bits above the index are not decoded, so the map repeats
  function [ADDR_W-1:0] word_idx;
    input [31:0] a;
    begin
      word_idx = a[ADDR_W+1:2];
    end
  endfunction

  // Valid transfer request in the address phase
  // IDLE and BUSY carry no transfer and are ignored
  function xfer_ok;
    input s;
    input [1:0] t;
    input r;
    begin
      xfer_ok = s & r & ((t == `SCCS_HTRANS_NONSEQ) | (t == `SCCS_HTRANS_SEQ));
    end
  endfunction

  // Write hit on one register word during the data phase
  function wr_hit;
    input              pend;
    input [ADDR_W-1:0] idx;
    input [ADDR_W-1:0] target;
    begin
      wr_hit = pend & (idx == target);
    end
  endfunction

  // Register state and sampled pin levels
  reg  [7:0]        contact_ctrl_reg_q;
  reg  [7:0]        iface_config_reg_q;
  reg  [7:0]        iface_status_reg_q;
  reg  [7:0]        irq_stat_q;
  reg  [7:0]        irq_mask_q;
  reg               wr_pend_q;
  reg  [ADDR_W-1:0] wr_idx_q;
  reg               clk_lvl_q;
  reg               rst_lvl_q;
  reg               pres_q;
  reg               vok_q;
  reg               ovc_q;

  // Address-phase decode; reads act at once, writes one cycle later
  wire              acc      = xfer_ok(hsel, htrans, hready);
  wire              rd_acc   = acc & ~hwrite;
  wire [ADDR_W-1:0] acc_idx  = word_idx(haddr);
  wire              wr_now   = wr_pend_q;
  wire              st_rd    = rd_acc & (acc_idx == `SCCS_IDX_STATUS);
  wire              data_rd  = rd_acc & (acc_idx == `SCCS_IDX_DATA);
  wire              data_wr  = wr_hit(wr_now, wr_idx_q, `SCCS_IDX_DATA);
  wire              pwr      = contact_ctrl_reg_q[`SCCS_CC_PWR];
  wire              cc_allow = pwr & vok_q;

  // Write data arrives one cycle after the address; hreadyout never stalls,
  // so a read directly after a write to the same word sees the old value.
  // hsize is not checked: every register is one aligned word
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= {ADDR_W{1'b0}};
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ce) begin
      wr_pend_q <= acc & hwrite;
      wr_idx_q  <= acc_idx;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // reset to unpowered
  // Contact, config and mask registers
  // Status and unmapped words ignore writes; the bus still answers OKAY
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      contact_ctrl_reg_q <= `SCCS_CC_RESET;
      iface_config_reg_q <= `SCCS_CF_RESET;
      irq_mask_q         <= `SCCS_IRQ_MASK_RESET;
    end else if (ce && wr_now) begin
      case (wr_idx_q)
        `SCCS_IDX_CONTACT:  contact_ctrl_reg_q <= hwdata[7:0];
        `SCCS_IDX_CONFIG:   iface_config_reg_q <= hwdata[7:0];
        `SCCS_IDX_IRQ_MASK: irq_mask_q         <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // Level inputs sampled once; pins treated as synchronous
  // The extra flop costs a cycle but keeps status and gating in step
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pres_q <= 1'b0;
      vok_q  <= 1'b0;
      ovc_q  <= 1'b0;
    end else if (ce) begin
      pres_q <= card_present;
      vok_q  <= voltage_in_range;
      ovc_q  <= overcurrent_in;
    end
  end

  // Status register; every set beats a clear in the same cycle
  // so an event never slips past a read that clears its bit
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      iface_status_reg_q <= `SCCS_ST_RESET;
    end else if (ce) begin
      if (tx_load_evt)
        iface_status_reg_q[`SCCS_ST_TBE] <= 1'b1;
      else if (data_wr)
        iface_status_reg_q[`SCCS_ST_TBE] <= 1'b0;
      // Raw level: contact bounce reaches software unfiltered
      // presence level
      iface_status_reg_q[`SCCS_ST_PRES] <= pres_q;
      iface_status_reg_q[`SCCS_ST_OVC]  <= ovc_q;
      iface_status_reg_q[`SCCS_ST_VOK]  <= vok_q;
      if (wait_expire_evt)
        iface_status_reg_q[`SCCS_ST_WTO] <= 1'b1;
      else if (wait_reload_evt)
        iface_status_reg_q[`SCCS_ST_WTO] <= 1'b0;
      if (tx_done_ok_evt)
        iface_status_reg_q[`SCCS_ST_TC] <= 1'b1;
      else if (st_rd)
        iface_status_reg_q[`SCCS_ST_TC] <= 1'b0;
      if (rx_done_ok_evt)
        iface_status_reg_q[`SCCS_ST_RC] <= 1'b1;
      else if (data_rd)
        iface_status_reg_q[`SCCS_ST_RC] <= 1'b0;
      if (parity_err_evt)
        iface_status_reg_q[`SCCS_ST_PE] <= 1'b1;
      else if (st_rd)
        iface_status_reg_q[`SCCS_ST_PE] <= 1'b0;
    end
  end

  // Interrupt events, one per status bit position
  // Presence and voltage flag either edge, overcurrent only its rise
  wire [7:0] evt = {tx_load_evt,
                    pres_q ^ iface_status_reg_q[`SCCS_ST_PRES],
                    ovc_q & ~iface_status_reg_q[`SCCS_ST_OVC],
                    vok_q ^ iface_status_reg_q[`SCCS_ST_VOK],
                    wait_expire_evt,
                    tx_done_ok_evt,
                    rx_done_ok_evt,
                    parity_err_evt};
  wire [7:0] w1c = {8{wr_hit(wr_now, wr_idx_q, `SCCS_IDX_IRQ_STAT)}} & hwdata[7:0];

  // Sticky bits, write one to clear, set wins
  // A clear that meets a new event leaves the bit set, so none is lost
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_irq
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
          irq_stat_q[g] <= 1'b0;
        else if (ce)
          irq_stat_q[g] <= evt[g] | (irq_stat_q[g] & ~w1c[g]);
      end
    end
  endgenerate

  // Interrupt output from a flop, one cycle behind the sticky bits
  // Masking after the sticky bits lets software poll masked events
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      irq <= 1'b0;
    else if (ce)
      irq <= |(irq_stat_q & irq_mask_q);
  end

  // Contact levels that follow only while powered with voltage good
  // Voltage out of range holds the last levels instead of dropping them
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_lvl_q <= 1'b0;
      rst_lvl_q <= 1'b0;
    end else if (ce) begin
      if (!pwr) begin
        clk_lvl_q <= 1'b0;
        rst_lvl_q <= 1'b0;
      end else if (cc_allow) begin
        clk_lvl_q <= contact_ctrl_reg_q[`SCCS_CC_CLKLVL];
        rst_lvl_q <= contact_ctrl_reg_q[`SCCS_CC_RST];
      end
    end
  end

  // Contact pins; pseudo-bidirectional pins drive low actively and let
  // the pull-up give the high level, so the card can pull them down.
  // The card clock is resampled by hclk: up to one hclk of jitter
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      card_power_on    <= 1'b0;
      card_clk_o       <= 1'b0;
      card_rst_o       <= 1'b0;
      io_pin_o         <= 1'b0;
      io_pin_oe        <= 1'b0;
      aux_pin_eight_o  <= 1'b0;
      aux_pin_eight_oe <= 1'b0;
      aux_pin_four_o   <= 1'b0;
      aux_pin_four_oe  <= 1'b0;
    end else if (ce) begin
      // Power-off forces every contact low or released in one cycle
      // power and deactivation
      card_power_on <= pwr;
      if (!pwr) begin
        card_clk_o       <= 1'b0;
        card_rst_o       <= 1'b0;
        io_pin_o         <= 1'b0;
        io_pin_oe        <= 1'b0;
        aux_pin_eight_o  <= 1'b0;
        aux_pin_eight_oe <= 1'b0;
        aux_pin_four_o   <= 1'b0;
        aux_pin_four_oe  <= 1'b0;
      end else begin
        card_clk_o <= contact_ctrl_reg_q[`SCCS_CC_CLKSEL] ?
                      generated_card_clock : clk_lvl_q;
        card_rst_o <= rst_lvl_q;
        io_pin_o  <= 1'b0;
        io_pin_oe <= iface_config_reg_q[`SCCS_CF_UART] ?
                     ~uart_io_level : ~contact_ctrl_reg_q[`SCCS_CC_IO];
        aux_pin_eight_o  <= 1'b0;
        aux_pin_eight_oe <= ~contact_ctrl_reg_q[`SCCS_CC_AUX8];
        aux_pin_four_o   <= 1'b0;
        aux_pin_four_oe  <= ~contact_ctrl_reg_q[`SCCS_CC_AUX4];
      end
    end
  end

  // Config fields out to the converter and the UART core
  // Unused config bits are stored for readback and drive nothing
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      supply_voltage_select    <= 2'b00;
      overcurrent_limit_adjust <= 1'b0;
      uart_select              <= 1'b0;
    end else if (ce) begin
      supply_voltage_select    <= iface_config_reg_q[`SCCS_CF_VSEL_HI:`SCCS_CF_VSEL_LO];
      overcurrent_limit_adjust <= iface_config_reg_q[`SCCS_CF_OVC_ADJ];
      uart_select              <= iface_config_reg_q[`SCCS_CF_UART];
    end
  end

  // Transmit data buffer and its one-cycle write strobe
  // The strobe lets the UART core load the byte right after it lands
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_data    <= 8'h00;
      tx_data_wr <= 1'b0;
    end else if (ce) begin
      tx_data_wr <= data_wr;
      if (data_wr)
        tx_data <= hwdata[7:0];
    end
  end

  // Read mux; contact readback shows the pin levels for IO and aux bits
  // The reserved contact bit and unmapped words read as zero
  reg [7:0] rd_d;
  always @* begin
    rd_d = 8'h00;
    case (acc_idx)
      `SCCS_IDX_CONTACT: begin
        rd_d = contact_ctrl_reg_q;
        rd_d[`SCCS_CC_RSVD]    = 1'b0;
        rd_d[`SCCS_CC_AUX8]    = aux_pin_eight_i;
        rd_d[`SCCS_CC_AUX4]    = aux_pin_four_i;
        rd_d[`SCCS_CC_IO]      = io_pin_i;
      end
      `SCCS_IDX_STATUS:   rd_d = iface_status_reg_q;
      `SCCS_IDX_CONFIG:   rd_d = iface_config_reg_q;
      `SCCS_IDX_DATA:     rd_d = rx_data;
      `SCCS_IDX_IRQ_STAT: rd_d = irq_stat_q;
      `SCCS_IDX_IRQ_MASK: rd_d = irq_mask_q;
      default:            rd_d = 8'h00;
    endcase
  end

  // Read data captured at the address phase, shown in the data phase
  // Zero outside read data phases, so stale data never lingers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (ce) begin
      if (rd_acc)
        hrdata <= {24'h00_0000, rd_d};
      else
        hrdata <= 32'h0000_0000;
    end
  end

endmodule // sccs_contacts

// ### sccs_tail_unused.v
`timescale 1ns/1ps

// ### sccs_card_model.sv
`timescale 1ns/1ps
module sccs_card_model (
  input  wire insert,
  input  wire drive_low,
  input  wire card_power_on,
  input  wire io_pin_oe,
  input  wire aux_pin_eight_oe,
  input  wire aux_pin_four_oe,
  output wire card_present,
  output wire io_pin_i,
  output wire aux_pin_eight_i,
  output wire aux_pin_four_i
);
  // raw presence level
  // No debouncing here, software has to filter it
  assign card_present = insert;
  // pulled-up contact lines
  // Either side can only pull low; an unpowered card never drives
  assign io_pin_i        = !(io_pin_oe || (drive_low && card_power_on));
  assign aux_pin_eight_i = !aux_pin_eight_oe;
  assign aux_pin_four_i  = !aux_pin_four_oe;
endmodule // sccs_card_model

// ### sccs_contacts_properties.sv
`timescale 1ns/1ps
module sccs_contacts_chk (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire [31:0] hrdata,
  input wire        voltage_in_range,
  input wire        io_pin_o,
  input wire        io_pin_oe,
  input wire        aux_pin_eight_o,
  input wire        aux_pin_four_o,
  input wire        card_rst_o,
  input wire        card_power_on,
  input wire        uart_select,
  input wire        tx_data_wr
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Transfer accepted at this edge
  wire acc = hsel && hready && htrans[1];
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or response not okay");
  chk_upper_zero: assert property (hrdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  chk_rdata_idle: assert property (!(acc && !hwrite) |=> hrdata == 32'h0000_0000)
    else $error("read data lingers without a read");
  chk_txwr_after: assert property (acc && hwrite && haddr[13:2] == 12'h0af |-> ##[1:3] tx_data_wr)
    else $error("data write gave no transmit strobe");
  chk_pins_low: assert property (!io_pin_o && !aux_pin_eight_o && !aux_pin_four_o)
    else $error("contact driven high instead of released");
  chk_off_released: assert property (!card_power_on && !$past(card_power_on) |-> !io_pin_oe && !card_rst_o)
    else $error("contact active while card unpowered");
  // Gated by the sampled voltage, so allow the sync delay
  chk_rst_hold: assert property ((!voltage_in_range) [*4] ##0 (card_power_on && $past(card_power_on)) |-> $stable(card_rst_o))
    else $error("reset contact moved with voltage out of range");
  chk_cfg_stable: assert property ((!(acc && hwrite)) [*4] |-> $stable(uart_select))
    else $error("uart select changed without a write");
  chk_pwr_stable: assert property ((!(acc && hwrite)) [*4] |-> $stable(card_power_on))
    else $error("card power changed without a write");
  cover property (acc && !hwrite);
  cover property (tx_data_wr);
  cover property (card_power_on && card_rst_o);
endmodule // sccs_contacts_chk
bind sccs_contacts sccs_contacts_chk sccs_contacts_chk_i (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .voltage_in_range(voltage_in_range),
  .io_pin_o(io_pin_o), .io_pin_oe(io_pin_oe), .aux_pin_eight_o(aux_pin_eight_o),
  .aux_pin_four_o(aux_pin_four_o),
  .card_rst_o(card_rst_o), .card_power_on(card_power_on), .uart_select(uart_select),
  .tx_data_wr(tx_data_wr));

// ### sccs_contacts_tb.sv
`timescale 1ns/1ps
`include "sccs_defines.vh"
module sccs_contacts_tb;
  reg         hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rdy_s = 1'b0;
  reg  [1:0]  htrans = 2'b00;
  reg  [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rd_s, rd;
  reg  [31:0] seed = 32'h0000_0048;
  reg  [5:0]  ev = 6'h00;
  reg  [7:0]  rx_byte = 8'h00;
  reg  [7:0]  txq[$];
  reg         insert = 1'b0, drive_low = 1'b0, ovc = 1'b0, vok = 1'b0, gclk = 1'b0, uio = 1'b0;
  wire        hreadyout, io_oe, a8_oe, a4_oe, io_i, a8_i, a4_i, pres, clk_o, rst_o, pwr, usel, irq;
  reg         ce = 1'b1;
  wire        ovadj;
  wire [1:0]  vsel;
  wire [31:0] hrdata;
  wire [7:0]  tx_data;
  integer     fail_count = 0, checks_done = 0, st = 8'h80, i;
  // Clock and mid-cycle sampling of the bus answer, clear of edge races
  always #25 hclk = ~hclk;
  always @(negedge hclk) begin
    rdy_s <= hreadyout;
    rd_s  <= hrdata;
  end
  sccs_contacts sccs_contacts_i (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .card_present(pres),
    .overcurrent_in(ovc), .voltage_in_range(vok), .generated_card_clock(gclk),
    .tx_load_evt(ev[0]), .tx_done_ok_evt(ev[1]), .rx_done_ok_evt(ev[2]), .parity_err_evt(ev[3]),
    .wait_expire_evt(ev[4]), .wait_reload_evt(ev[5]), .uart_io_level(uio), .rx_data(rx_byte),
    .io_pin_i(io_i), .aux_pin_eight_i(a8_i), .aux_pin_four_i(a4_i), .io_pin_o(),
    .io_pin_oe(io_oe), .aux_pin_eight_o(), .aux_pin_eight_oe(a8_oe), .aux_pin_four_o(),
    .aux_pin_four_oe(a4_oe), .card_clk_o(clk_o), .card_rst_o(rst_o), .card_power_on(pwr),
    .supply_voltage_select(vsel), .overcurrent_limit_adjust(ovadj), .uart_select(usel),
    .tx_data(tx_data), .tx_data_wr(), .irq(irq));
  sccs_card_model sccs_card_model_i (.insert(insert), .drive_low(drive_low),
    .card_power_on(pwr), .io_pin_oe(io_oe), .aux_pin_eight_oe(a8_oe), .aux_pin_four_oe(a4_oe),
    .card_present(pres), .io_pin_i(io_i), .aux_pin_eight_i(a8_i), .aux_pin_four_i(a4_i));
  function [31:0] xs(input [31:0] s);
    xs = s ^ (s << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge hclk);
  endtask
  // One single transfer; the master never assumes the slave's latency
  task bus(input [11:0] idx, input wr, input [31:0] d);
    hsel <= 1'b1;
    htrans <= `SCCS_HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {18'h0_0000, idx, 2'b00};
    do @(posedge hclk); while (rdy_s !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (rdy_s !== 1'b1);
    rd = rd_s;
  endtask
  task wt(input [11:0] idx, input [31:0] d);
    bus(idx, 1'b1, d);
    tick(3);
  endtask
  task rdc(input [11:0] idx, input [31:0] exp, input string nm);
    bus(idx, 1'b0, 32'h0000_0000);
    chk(nm, rd, exp);
  endtask
  task pulse(input [5:0] m);
    ev <= m;
    @(posedge hclk);
    ev <= 6'h00;
    tick(3);
  endtask
  task finish_test;
    if (fail_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    #(4000 * 50);
    fail_count++;
    finish_test;
  end
  // Main sequence; released pins read back high through the pull-ups
  initial begin
    tick(12);
    hresetn <= 1'b1;
    tick(1);
    rdc(`SCCS_IDX_STATUS, 32'h0000_0080, "status");
    rdc(`SCCS_IDX_CONTACT, 32'h0000_0038, "contact");
    rdc(12'h0c0, 32'h0000_0000, "unmapped");
    insert <= 1'b1;
    ovc <= 1'b1;
    vok <= 1'b1;
    tick(4);
    rdc(`SCCS_IDX_STATUS, 32'h0000_00f0, "status");
    chk("irq", irq, 1'b0);
    ovc <= 1'b0;
    wt(`SCCS_IDX_IRQ_MASK, 32'h0000_0020);
    chk("irq", irq, 1'b1);
    wt(`SCCS_IDX_IRQ_STAT, 32'h0000_00ff);
    chk("irq", irq, 1'b0);
    wt(`SCCS_IDX_CONTACT, 32'h0000_0003);
    chk("power", {pwr, rst_o}, 2'b11);
    vok <= 1'b0;
    tick(4);
    wt(`SCCS_IDX_CONTACT, 32'h0000_0001);
    chk("reset", rst_o, 1'b1);
    vok <= 1'b1;
    tick(4);
    chk("reset", rst_o, 1'b0);
    wt(`SCCS_IDX_CONTACT, 32'h0000_0005);
    chk("clock", clk_o, 1'b1);
    wt(`SCCS_IDX_CONTACT, 32'h0000_0081);
    for (i = 0; i < 6; i++) begin
      seed = xs(seed);
      gclk <= seed[0];
      tick(3);
      chk("clock", clk_o, gclk);
    end
    wt(`SCCS_IDX_CONTACT, 32'h0000_0039);
    rdc(`SCCS_IDX_CONTACT, 32'h0000_0039, "contact");
    drive_low <= 1'b1;
    tick(2);
    rdc(`SCCS_IDX_CONTACT, 32'h0000_0031, "contact");
    drive_low <= 1'b0;
    wt(`SCCS_IDX_CONTACT, 32'h0000_0001);
    chk("pins", {io_oe, a8_oe, a4_oe}, 3'b111);
    rdc(`SCCS_IDX_CONTACT, 32'h0000_0001, "contact");
    wt(`SCCS_IDX_CONTACT, 32'h0000_0009);
    wt(`SCCS_IDX_CONFIG, 32'h0000_0078);
    chk("uart", {usel, io_oe}, 2'b11);
    chk("config", {ovadj, vsel}, 3'b111);
    rdc(`SCCS_IDX_CONFIG, 32'h0000_0078, "config");
    uio <= 1'b1;
    tick(3);
    chk("uart", io_oe, 1'b0);
    wt(`SCCS_IDX_CONFIG, 32'h0000_0000);
    wt(`SCCS_IDX_CONTACT, 32'h0000_003e);
    chk("off", {pwr, rst_o, io_oe, a8_oe}, 4'h0);
    pulse(6'h1e);
    st = st | 8'h0f;
    rdc(`SCCS_IDX_STATUS, st | 8'h50, "status");
    st = st & ~8'h05;
    rdc(`SCCS_IDX_STATUS, st | 8'h50, "status");
    pulse(6'h20);
    st = st & ~8'h08;
    seed = xs(seed);
    rx_byte <= seed[7:0];
    tick(1);
    rdc(`SCCS_IDX_DATA, {24'h00_0000, rx_byte}, "data");
    st = st & ~8'h02;
    rdc(`SCCS_IDX_STATUS, st | 8'h50, "status");
    seed = xs(seed);
    txq.push_back(seed[7:0]);
    wt(`SCCS_IDX_DATA, seed);
    chk("tx_data", tx_data, txq.pop_front());
    st = st & ~8'h80;
    rdc(`SCCS_IDX_STATUS, st | 8'h50, "status");
    pulse(6'h01);
    st = st | 8'h80;
    rdc(`SCCS_IDX_STATUS, st | 8'h50, "status");
    // Clock enable low: an event in that span is lost
    ce <= 1'b0;
    pulse(6'h10);
    ce <= 1'b1;
    rdc(`SCCS_IDX_STATUS, st | 8'h50, "status");
    finish_test;
  end
endmodule // sccs_contacts_tb
